// ---- common/cfg_bank_pkg.sv ----
/*
  Constants, field layouts and carrier types for the cluster and
  interconnect configuration register bank.
  Assumes a 32-bit AXI4-Lite register bus and one clock domain.
*/
package cfg_bank_pkg;

  // ************************************************************
  // Bus and register map
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam logic [ADDR_W-1:0] OFS_CLUSTER_0 = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CLUSTER_1 = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_REGION_MAP = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_ICN_1 = 12'h00C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Writable masks and reset values
  // ************************************************************
  localparam logic [31:0] MASK_CLUSTER_0 = 32'h7777_770F;
  localparam logic [31:0] MASK_CLUSTER_1 = 32'h0003_F777;
  localparam logic [31:0] MASK_REGION_MAP = 32'hFFFF_FFFF;
  localparam logic [31:0] MASK_ICN_1 = 32'h01FF_FFFF;
  localparam logic [31:0] RST_CLUSTER_0 = 32'h7770_0000;
  localparam logic [31:0] RST_CLUSTER_1 = 32'h0001_8007;
  localparam logic [31:0] RST_REGION_MAP = 32'h5555_5500;
  localparam logic [31:0] RST_ICN_1 = 32'h0186_0038;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CORES = 3;
  localparam int C0_SEC_INV_LSB = 28;
  localparam int C0_NONINV_LSB = 24;
  localparam int C0_INV_LSB = 20;
  localparam int C0_EXC_STATE_LSB = 16;
  localparam int C0_HIVEC_LSB = 12;
  localparam int C0_BIGEND_LSB = 8;
  localparam int C0_CLUSTER_LSB = 0;
  localparam int CLUSTER_W = 4;
  localparam int C1_MAINT_BIT = 17;
  localparam int C1_OUTER_BIT = 16;
  localparam int C1_INNER_BIT = 15;
  localparam int C1_BARRIER_BIT = 14;
  localparam int C1_SNOOP_BIT = 13;
  localparam int C1_L2_INVAL_BIT = 12;
  localparam int C1_L1_INVAL_LSB = 8;
  localparam int C1_WLOCK_LSB = 4;
  localparam int C1_SEC_NONINV_LSB = 0;
  localparam int REGIONS = 16;
  localparam int REGION_FIELD_W = 2;
  localparam int LOW_REGIONS = 8;
  localparam int I1_NONINV_BIT = 24;
  localparam int I1_SEC_NONINV_BIT = 23;
  localparam int I1_REV_LSB = 19;
  localparam int REV_W = 4;
  localparam int I1_SNOOP_REQ_LSB = 14;
  localparam int I1_QOS_LSB = 9;
  localparam int SLAVE_PORTS = 5;
  localparam int I1_NONBUF_LSB = 6;
  localparam int I1_BARSTOP_LSB = 3;
  localparam int I1_MAINT_LSB = 0;
  localparam int MASTER_PORTS = 3;

  // ************************************************************
  // Address space of the region map
  // ************************************************************
  localparam int PROBE_W = 40;
  localparam int LOW_TOP_BIT = 32;
  localparam int LOW_REGION_LSB = 29;
  localparam logic [31:0] HIGH_VECTOR_BASE = 32'hFFFF_0000;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic [CORES-1:0] secure_invasive_dbg_en;
    logic [CORES-1:0] noninvasive_dbg_en;
    logic [CORES-1:0] invasive_dbg_en;
    logic [CORES-1:0] exception_state_sel;
    logic [CORES-1:0] high_vector_sel;
    logic [CORES-1:0] big_endian_sel;
    logic [CLUSTER_W-1:0] cluster_number_bus;
    logic maint_broadcast_en;
    logic outer_share_broadcast_en;
    logic inner_share_broadcast_en;
    logic barrier_broadcast_off;
    logic snoop_port_off;
    logic l2_reset_inval_off;
    logic [CORES-1:0] l1_reset_inval_off;
    logic [CORES-1:0] secure_reg_write_lock;
    logic [CORES-1:0] secure_noninvasive_dbg_en;
  } cluster_cfg_t;

  typedef struct packed {
    logic [REGIONS*REGION_FIELD_W-1:0] region_decode;
    logic noninvasive_dbg_en;
    logic secure_noninvasive_dbg_en;
    logic [REV_W-1:0] fix_revision;
    logic [SLAVE_PORTS-1:0] snoop_request_en;
    logic [SLAVE_PORTS-1:0] qos_force;
    logic [MASTER_PORTS-1:0] nonbuffer_force;
    logic [MASTER_PORTS-1:0] barrier_stop;
    logic [MASTER_PORTS-1:0] maint_broadcast_en;
  } icn_cfg_t;

endpackage

// ---- hdl/cfg_word.sv ----
/*
  One 32-bit configuration word with byte strobes and a writable mask.
  Assumes a single-cycle write enable from the bus slave.
*/
module cfg_word #(
  parameter logic [31:0] RESET_VALUE = 32'h0000_0000,
  parameter logic [31:0] WRITE_MASK = 32'hFFFF_FFFF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [cfg_bank_pkg::DATA_W-1:0] wr_data,
  input wire logic [cfg_bank_pkg::STRB_W-1:0] wr_strb,
  output logic [cfg_bank_pkg::DATA_W-1:0] value_q
);

  logic [cfg_bank_pkg::DATA_W-1:0] value_d;

  // ************************************************************
  // Byte-lane merge, reserved bits held at zero
  // ************************************************************
  always_comb begin
    value_d = value_q;
    for (int b = 0; b < cfg_bank_pkg::STRB_W; b++) begin
      if (wr_en && wr_strb[b]) begin
        value_d[b*8 +: 8] = wr_data[b*8 +: 8] & WRITE_MASK[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_q <= RESET_VALUE;
    end else begin
      value_q <= value_d;
    end
  end

endmodule

// ---- hdl/axil_slave_port.sv ----
/*
  AXI4-Lite slave handshake: one write and one read at a time.
  Assumes the parent decodes addresses combinationally.
*/
module axil_slave_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cfg_bank_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [cfg_bank_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [cfg_bank_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cfg_bank_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [cfg_bank_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [cfg_bank_pkg::ADDR_W-1:0] wr_addr,
  output logic [cfg_bank_pkg::DATA_W-1:0] wr_data,
  output logic [cfg_bank_pkg::STRB_W-1:0] wr_strb,
  input wire logic wr_hit,
  output logic [cfg_bank_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [cfg_bank_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_hit
);

  logic aw_have_q;
  logic w_have_q;

  // ************************************************************
  // Write channels
  // ************************************************************
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign wr_en = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      wr_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      wr_addr <= s_axi_awaddr;
    end else if (wr_en) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (wr_en) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cfg_bank_pkg::RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? cfg_bank_pkg::RESP_OKAY : cfg_bank_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Read channels
  // ************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= cfg_bank_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? cfg_bank_pkg::RESP_OKAY : cfg_bank_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ---- hdl/cluster_icn_cfg.sv ----
/*
  Configuration register bank for a three-core cluster and a coherent
  interconnect, reached over AXI4-Lite, with a region-map lookup port.
  Assumes one clock, synchronous active-low reset, synchronous inputs.
*/
// Added by the designer: the address map and the AXI4-Lite register port.
module cluster_icn_cfg #(
  parameter logic [cfg_bank_pkg::CLUSTER_W-1:0] CLUSTER_NUMBER = 4'h1,
  // Arbitrary neutral revision value
  parameter logic [cfg_bank_pkg::REV_W-1:0] FIX_REVISION = 4'h5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [cfg_bank_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [cfg_bank_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [cfg_bank_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cfg_bank_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [cfg_bank_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output cfg_bank_pkg::cluster_cfg_t cluster_cfg,
  output cfg_bank_pkg::icn_cfg_t icn_cfg,
  output logic [cfg_bank_pkg::DATA_W-1:0] vector_base [cfg_bank_pkg::CORES],
  input wire logic [cfg_bank_pkg::PROBE_W-1:0] probe_addr,
  output logic [3:0] probe_region_q,
  output logic [cfg_bank_pkg::REGION_FIELD_W-1:0] probe_target_q
);

  // ************************************************************
  // Local types and helpers
  // ************************************************************
  localparam int NREGS = 4;
  typedef logic [cfg_bank_pkg::DATA_W-1:0] word_t;

  // Word index of a mapped byte address, or NREGS when unmapped
  function automatic logic [2:0] reg_index(input logic [cfg_bank_pkg::ADDR_W-1:0] a);
    logic [2:0] idx;
    idx = 3'(NREGS);
    unique case (a)
      cfg_bank_pkg::OFS_CLUSTER_0: idx = 3'h0;
      cfg_bank_pkg::OFS_CLUSTER_1: idx = 3'h1;
      cfg_bank_pkg::OFS_REGION_MAP: idx = 3'h2;
      cfg_bank_pkg::OFS_ICN_1: idx = 3'h3;
      default: idx = 3'(NREGS);
    endcase
    return idx;
  endfunction

  // Region number of a byte address in the forty-bit map
  function automatic logic [3:0] region_of(input logic [cfg_bank_pkg::PROBE_W-1:0] a);
    logic [3:0] r;
    r = {1'b0, a[cfg_bank_pkg::LOW_TOP_BIT-1:cfg_bank_pkg::LOW_REGION_LSB]};
    for (int i = 0; i < cfg_bank_pkg::PROBE_W - cfg_bank_pkg::LOW_TOP_BIT; i++) begin
      if (a[cfg_bank_pkg::LOW_TOP_BIT + i]) begin
        r = 4'(cfg_bank_pkg::LOW_REGIONS + i);
      end
    end
    return r;
  endfunction

  // Vector base chosen by one select bit
  function automatic word_t vector_of(input logic hi);
    return hi ? cfg_bank_pkg::HIGH_VECTOR_BASE : 32'h0000_0000;
  endfunction

  // ************************************************************
  // Bus slave
  // ************************************************************
  logic wr_en;
  logic [cfg_bank_pkg::ADDR_W-1:0] wr_addr;
  word_t wr_data;
  logic [cfg_bank_pkg::STRB_W-1:0] wr_strb;
  logic [cfg_bank_pkg::ADDR_W-1:0] rd_addr;
  word_t rd_data;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  word_t regs [NREGS];

  assign wr_idx = reg_index(wr_addr);
  assign rd_idx = reg_index(rd_addr);

  axil_slave_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_idx != 3'(NREGS)),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_idx != 3'(NREGS))
  );

  // Reserved bits read as zero, unmapped reads return zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (rd_idx != 3'(NREGS)) begin
      rd_data = regs[rd_idx[1:0]];
    end
  end

  // ************************************************************
  // Register words
  // ************************************************************
  localparam word_t RST_C0 = cfg_bank_pkg::RST_CLUSTER_0
    | (word_t'(CLUSTER_NUMBER) << cfg_bank_pkg::C0_CLUSTER_LSB);
  localparam word_t RST_I1 = cfg_bank_pkg::RST_ICN_1
    | (word_t'(FIX_REVISION) << cfg_bank_pkg::I1_REV_LSB);

  // debug enables reset to all ones in these defaults
  cfg_word #(.RESET_VALUE(RST_C0), .WRITE_MASK(cfg_bank_pkg::MASK_CLUSTER_0)) u_c0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_en && wr_idx == 3'h0),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .value_q(regs[0])
  );

  cfg_word #(.RESET_VALUE(cfg_bank_pkg::RST_CLUSTER_1),
    .WRITE_MASK(cfg_bank_pkg::MASK_CLUSTER_1)) u_c1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_en && wr_idx == 3'h1),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .value_q(regs[1])
  );

  // Region defaults: 01 from region 4 upward
  cfg_word #(.RESET_VALUE(cfg_bank_pkg::RST_REGION_MAP),
    .WRITE_MASK(cfg_bank_pkg::MASK_REGION_MAP)) u_map (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_en && wr_idx == 3'h2),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .value_q(regs[2])
  );

  cfg_word #(.RESET_VALUE(RST_I1), .WRITE_MASK(cfg_bank_pkg::MASK_ICN_1)) u_i1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr_en && wr_idx == 3'h3),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .value_q(regs[3])
  );

  // ************************************************************
  // Cluster outputs
  // ************************************************************
  localparam int N = cfg_bank_pkg::CORES;

  always_comb begin
    cluster_cfg.secure_invasive_dbg_en = regs[0][cfg_bank_pkg::C0_SEC_INV_LSB +: N];
    cluster_cfg.noninvasive_dbg_en = regs[0][cfg_bank_pkg::C0_NONINV_LSB +: N];
    cluster_cfg.invasive_dbg_en = regs[0][cfg_bank_pkg::C0_INV_LSB +: N];
    cluster_cfg.exception_state_sel = regs[0][cfg_bank_pkg::C0_EXC_STATE_LSB +: N];
    cluster_cfg.high_vector_sel = regs[0][cfg_bank_pkg::C0_HIVEC_LSB +: N];
    cluster_cfg.big_endian_sel = regs[0][cfg_bank_pkg::C0_BIGEND_LSB +: N];
    cluster_cfg.cluster_number_bus =
      regs[0][cfg_bank_pkg::C0_CLUSTER_LSB +: cfg_bank_pkg::CLUSTER_W];
    cluster_cfg.maint_broadcast_en = regs[1][cfg_bank_pkg::C1_MAINT_BIT];
    cluster_cfg.outer_share_broadcast_en = regs[1][cfg_bank_pkg::C1_OUTER_BIT];
    cluster_cfg.inner_share_broadcast_en = regs[1][cfg_bank_pkg::C1_INNER_BIT];
    cluster_cfg.barrier_broadcast_off = regs[1][cfg_bank_pkg::C1_BARRIER_BIT];
    cluster_cfg.snoop_port_off = regs[1][cfg_bank_pkg::C1_SNOOP_BIT];
    cluster_cfg.l2_reset_inval_off = regs[1][cfg_bank_pkg::C1_L2_INVAL_BIT];
    cluster_cfg.l1_reset_inval_off = regs[1][cfg_bank_pkg::C1_L1_INVAL_LSB +: N];
    cluster_cfg.secure_reg_write_lock = regs[1][cfg_bank_pkg::C1_WLOCK_LSB +: N];
    cluster_cfg.secure_noninvasive_dbg_en =
      regs[1][cfg_bank_pkg::C1_SEC_NONINV_LSB +: N];
  end

  // Per-core reset vector address
  always_comb begin
    for (int c = 0; c < N; c++) begin
      vector_base[c] = vector_of(cluster_cfg.high_vector_sel[c]);
    end
  end

  // ************************************************************
  // Interconnect outputs
  // ************************************************************
  localparam int M = cfg_bank_pkg::MASTER_PORTS;
  localparam int S = cfg_bank_pkg::SLAVE_PORTS;

  always_comb begin
    icn_cfg.region_decode = regs[2];
    icn_cfg.noninvasive_dbg_en = regs[3][cfg_bank_pkg::I1_NONINV_BIT];
    icn_cfg.secure_noninvasive_dbg_en = regs[3][cfg_bank_pkg::I1_SEC_NONINV_BIT];
    icn_cfg.fix_revision = regs[3][cfg_bank_pkg::I1_REV_LSB +: cfg_bank_pkg::REV_W];
    icn_cfg.snoop_request_en = regs[3][cfg_bank_pkg::I1_SNOOP_REQ_LSB +: S];
    icn_cfg.qos_force = regs[3][cfg_bank_pkg::I1_QOS_LSB +: S];
    icn_cfg.nonbuffer_force = regs[3][cfg_bank_pkg::I1_NONBUF_LSB +: M];
    icn_cfg.barrier_stop = regs[3][cfg_bank_pkg::I1_BARSTOP_LSB +: M];
    icn_cfg.maint_broadcast_en = regs[3][cfg_bank_pkg::I1_MAINT_LSB +: M];
  end

  // ************************************************************
  // Region lookup
  // ************************************************************
  logic [3:0] probe_region_d;

  assign probe_region_d = region_of(probe_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      probe_region_q <= 4'h0;
    end else begin
      probe_region_q <= probe_region_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      probe_target_q <= 2'h0;
    end else begin
      probe_target_q <= regs[2][probe_region_d * cfg_bank_pkg::REGION_FIELD_W +:
        cfg_bank_pkg::REGION_FIELD_W];
    end
  end

endmodule

// ---- verif/cfg_sink.sv ----
/*
  Model of the cluster and interconnect configuration inputs.
  Assumes the bank drives settled levels on the bench clock.
*/
module cfg_sink (
  input wire logic aclk,
  input wire cfg_bank_pkg::cluster_cfg_t cluster_cfg,
  input wire cfg_bank_pkg::icn_cfg_t icn_cfg,
  output cfg_bank_pkg::cluster_cfg_t seen_cl_q,
  output cfg_bank_pkg::icn_cfg_t seen_ic_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Static inputs latched as the cores see them
  // ****
  always_ff @(posedge aclk) begin
    seen_cl_q <= cluster_cfg;
    seen_ic_q <= icn_cfg;
  end
endmodule

// ---- verif/cluster_icn_cfg_assertions.sv ----
/*
  Port checker for the configuration bank.
  Assumes binding into cluster_icn_cfg with one clock.
*/
module cfg_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cfg_bank_pkg::cluster_cfg_t cluster_cfg,
  input wire cfg_bank_pkg::icn_cfg_t icn_cfg,
  input wire logic [31:0] vector_base [3],
  input wire logic [39:0] probe_addr,
  input wire logic [3:0] probe_region_q,
  input wire logic [1:0] probe_target_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Properties
  // ****
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
  property p_wr; s_wr |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write answer missing");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rd; s_rd |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_cfg;
    $past(aresetn) && ($changed(cluster_cfg) || $changed(icn_cfg)) |-> $rose(s_axi_bvalid);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config moved without a write");
  property p_rst;
    $rose(aresetn) |-> cluster_cfg.secure_invasive_dbg_en == 3'h7 &&
      cluster_cfg.invasive_dbg_en == 3'h7 && icn_cfg.region_decode == 32'h5555_5500 &&
      icn_cfg.barrier_stop == 3'h7 && cluster_cfg.high_vector_sel == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset defaults wrong");
  property p_vec;
    vector_base[0] == (cluster_cfg.high_vector_sel[0] ? 32'hFFFF_0000 : 32'h0000_0000) &&
      vector_base[2] == (cluster_cfg.high_vector_sel[2] ? 32'hFFFF_0000 : 32'h0000_0000);
  endproperty
  a_vec: assert property (p_vec) else $error("vector base wrong");
  property p_lo;
    probe_addr[39:32] == 8'h00 |=> probe_region_q == {1'b0, $past(probe_addr[31:29])} &&
      probe_target_q == 2'($past(icn_cfg.region_decode) >> {$past(probe_addr[31:29]), 1'b0});
  endproperty
  a_lo: assert property (p_lo) else $error("low region lookup wrong");
  property p_hi;
    probe_addr[39] |=> probe_region_q == 4'hF &&
      probe_target_q == $past(icn_cfg.region_decode[31:30]);
  endproperty
  a_hi: assert property (p_hi) else $error("top region lookup wrong");
endmodule

bind cluster_icn_cfg cfg_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .cluster_cfg(cluster_cfg), .icn_cfg(icn_cfg), .vector_base(vector_base),
  .probe_addr(probe_addr), .probe_region_q(probe_region_q), .probe_target_q(probe_target_q));

// ---- verif/test_cluster_icn_cfg.sv ----
/*
  Self-checking bench for the configuration bank.
  Assumes the bank answers over AXI4-Lite at 100 MHz.
*/
module test_cluster_icn_cfg;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] CL_NUM = 4'hA; // Arbitrary value
  localparam logic [3:0] REV = 4'h3; // Arbitrary value
  localparam logic [31:0] MSK [4] = '{32'h7777_770F, 32'h0003_F777, 32'hFFFF_FFFF, 32'h01FF_FFFF};
  localparam logic [11:0] BAD [3] = '{12'h010, 12'h002, 12'hFFC};
  localparam logic [39:0] PRB [4] = '{40'h0, 40'hFF_FFFF, 40'h1_0000_0000, 40'hFF_FFFF_FFFF};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [31:0] vector_base [3];
  logic [31:0] mdl [4];
  logic [3:0] s_axi_wstrb, probe_region_q, s, rg;
  logic [1:0] s_axi_bresp, s_axi_rresp, probe_target_q, r;
  logic [39:0] probe_addr, pa;
  cfg_bank_pkg::cluster_cfg_t cluster_cfg, seen_cl_q;
  cfg_bank_pkg::icn_cfg_t icn_cfg, seen_ic_q;
  int failures, n_checks, seed, k;
  cluster_icn_cfg #(.CLUSTER_NUMBER(CL_NUM), .FIX_REVISION(REV)) DUT (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cluster_cfg, .icn_cfg, .vector_base, .probe_addr, .probe_region_q,
    .probe_target_q);
  cfg_sink u_sink (.aclk, .cluster_cfg, .icn_cfg, .seen_cl_q, .seen_ic_q);
  // ****
  // Helpers
  // ****
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  function automatic cfg_bank_pkg::cluster_cfg_t exp_cl(logic [31:0] a, logic [31:0] b);
    return '{a[30:28], a[26:24], a[22:20], a[18:16], a[14:12], a[10:8], a[3:0],
      b[17], b[16], b[15], b[14], b[13], b[12], b[10:8], b[6:4], b[2:0]};
  endfunction
  function automatic cfg_bank_pkg::icn_cfg_t exp_ic(logic [31:0] m, logic [31:0] c);
    return '{m, c[24], c[23], c[22:19], c[18:14], c[13:9], c[8:6], c[5:3], c[2:0]};
  endfunction
  function automatic logic [3:0] exp_rg(logic [39:0] a);
    if (a[39:32] == 8'h00) return {1'b0, a[31:29]};
    for (int i = 7; i >= 0; i--) if (a[32+i]) return 4'(8 + i);
    return 4'h0;
  endfunction
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] ws);
    logic ta, tw, dn, bv;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_wstrb <= ws;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    dn = 1'b0;
    for (int n = 0; n < 50 && !dn; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      dn = bv && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      s_axi_bready <= bv && !dn;
    end
    if (!dn) failures++;
  endtask
  task automatic axr(input logic [11:0] a);
    logic ta, dn, rv;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    dn = 1'b0;
    for (int n = 0; n < 50 && !dn; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      dn = rv && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      s_axi_rready <= rv && !dn;
    end
    if (!dn) failures++;
  endtask
  task automatic chk_reg(input int i);
    axr(12'(4 * i));
    chk("rresp", 2'h0, r);
    chk("rdata", mdl[i], d);
    chk("cluster", exp_cl(mdl[0], mdl[1]), seen_cl_q);
    chk("icn", exp_ic(mdl[2], mdl[3]), seen_ic_q);
    chk("vector", mdl[0][13] ? 32'hFFFF_0000 : 32'h0, vector_base[1]);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    repeat (5000) @(posedge aclk);
    failures++;
    tally_and_finish();
  end
  initial begin
    seed = 47;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
    probe_addr = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    mdl = '{32'h7770_0000 | CL_NUM, 32'h0001_8007, 32'h5555_5500, 32'h0186_0038 | {REV, 19'h0}};
    for (int i = 0; i < 4; i++) chk_reg(i);
    $display("reset test done");
    for (int i = 0; i < 32; i++) begin
      k = (i < 8) ? i / 2 : $unsigned($random(seed)) % 4;
      d = (i < 8) ? (i[0] ? 32'h0 : MSK[k]) : $random(seed) & MSK[k];
      s = (i < 8) ? 4'hF : 4'($random(seed));
      axw(12'(4 * k), d, s);
      chk("bresp", 2'h0, r);
      for (int b = 0; b < 4; b++) if (s[b]) mdl[k][8*b+:8] = d[8*b+:8];
      chk_reg(k);
    end
    $display("write test done");
    foreach (BAD[i]) begin
      axw(BAD[i], 32'hFFFF_FFFF, 4'hF);
      chk("bad bresp", 2'h2, r);
      axr(BAD[i]);
      chk("bad rresp", 2'h2, r);
      chk("bad rdata", 32'h0, d);
      chk_reg(i);
    end
    $display("unmapped test done");
    for (int i = 0; i < 24; i++) begin
      pa = (i < 4) ? PRB[i] : 40'({$random(seed), $random(seed)}) >> ($unsigned($random(seed)) % 40);
      @(posedge aclk);
      probe_addr <= pa;
      @(posedge aclk);
      @(negedge aclk);
      rg = exp_rg(pa);
      chk("region", rg, probe_region_q);
      chk("target", mdl[2][2*rg+:2], probe_target_q);
    end
    $display("probe test done");
    tally_and_finish();
  end
endmodule
